// [core/rxd_dma.sv]
`timescale 1ns/100ps
module rxd_fifo #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// fill side
	input  wire logic             wValid,
	output logic                  wReady,
	input  wire logic [WIDTH-1:0] wData,
	// drain side
	output logic                  rValid,
	input  wire logic             rReady,
	output logic [WIDTH-1:0]      rData
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gBadDepth
		$error("fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_r;
	logic [AW:0]      rp_r;
	wire              full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	assign wReady = !full;
	assign rValid = wp_r != rp_r;
	assign rData  = mem[rp_r[AW-1:0]];
	always_ff @(posedge clk)
	begin
		if (wValid && wReady)
			mem[wp_r[AW-1:0]] <= wData;
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (wValid && wReady)
				wp_r <= wp_r + 1'b1;
			if (rValid && rReady)
				rp_r <= rp_r + 1'b1;
		end
	end
endmodule : rxd_fifo

// Overview of operation
// - all memory traffic goes through controller requests
// - free buffers come from small/large queues
// - finished packet reference goes to ready queue
// - per-channel context table, 256 entries
// - chain end set only on last descriptor
// - free descriptor chain end ignored, one buffer
// - offset bytes of filler precede packet data
// - later chain descriptors get offset zero
// - six-bit status, bit five written zero
// - valid status only in last descriptor
// - per-descriptor byte count excludes filler bytes
// - count above 32767 marks too-short packet
// - host ignores count on overrun or abort
// - non-final descriptors hold next reference
// - every descriptor carries the channel code
// - host sets sizes, multiples of sixteen, bounded
// - engine writes only its own descriptor fields
// - data stored at descriptor buffer address
// - descriptor address is table base plus reference
// - ready entry carries two-bit outcome code
// - substitute other queue; both empty raises error
module rxd_dma #(
	parameter int FIFO_DEPTH = 16
) (
	// controller side
	rxd_if.dev                  bus,
	// clock and reset
	input  wire logic           clk,
	input  wire logic           rstn,
	// packet byte stream
	input  wire logic           inValid,
	output logic                inReady,
	input  wire logic [7:0]     inData,
	input  wire logic [7:0]     inChan,
	input  wire logic           inLast,
	input  wire logic [4:0]     inStatus,
	input  wire logic [2:0]     inTrim,
	input  wire logic           inUnprov,
	input  wire logic           inRawMax,
	// configuration
	input  wire logic [27:0]    descTableBase,
	input  wire logic [29:0]    queueBase,
	input  wire logic [1:0]     rxOffset,
	input  wire logic           qInit,
	input  wire logic [2:0][15:0] qStart,
	input  wire logic [2:0][15:0] qEnd,
	input  wire logic [1:0][15:0] freeWrIdx,
	input  wire logic [15:0]    readyRdIdx,
	// queue state
	output logic [1:0][15:0]    freeRdIdx,
	output logic [15:0]         readyWrIdx,
	output logic                queueErrorIrq
);
	typedef enum logic [3:0] {
		S_IDLE, S_WORD, S_GETREF, S_QRD, S_LINK2, S_LINK3, S_RDA, S_RDS, S_CLOSE2, S_CLOSE3, S_RDYQ
	} rxd_state_t;
	localparam int FW = 27;

	rxd_state_t          state_r;
	rxd_pkg::rxd_ctx_t   cx_r;
	rxd_pkg::rxd_ctx_t   tbl [rxd_pkg::CHANNELS];
	logic [7:0]          cxChan_r;
	logic [rxd_pkg::CHANNELS-1:0] act_r;
	logic                go_r;
	logic                rdWait_r;
	logic                qSel_r;
	logic [14:0]         newRef_r;
	logic [4:0]          stat_r;
	logic [2:0]          trim_r;
	logic [1:0]          code_r;
	logic                last_r;
	logic                errArm_r;
	logic [1:0][15:0]    freeRd_r;
	logic [15:0]         readyWr_r;
	logic [31:0]         reqAddr_r;
	logic [31:0]         reqData_r;
	logic                reqWrite_r;
	logic [31:0]         addrC;
	logic [31:0]         dataC;

	// byte stream fifo
	logic                fValid;
	logic                fReady;
	logic [FW-1:0]       fData;
	rxd_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) uFifo (
		.clk    (clk),
		.rstn   (rstn),
		.wValid (inValid),
		.wReady (inReady),
		.wData  ({inRawMax, inUnprov, inTrim, inStatus, inLast, inChan, inData}),
		.rValid (fValid),
		.rReady (fReady),
		.rData  (fData)
	);
	wire [7:0]  fByte   = fData[7:0];
	wire [7:0]  fChan   = fData[15:8];
	wire        fLast   = fData[16];
	wire [4:0]  fStat   = fData[21:17];
	wire [2:0]  fTrim   = fData[24:22];
	wire        fUnprov = fData[25];
	wire        fRawMax = fData[26];

	// decode of the loaded channel
	wire        chanHit = fChan == cxChan_r;
	wire        act     = act_r[cxChan_r];
	wire [15:0] used    = cx_r.cnt + {14'h0, cx_r.off};
	wire        full    = used == cx_r.bufSize;
	wire        take    = (state_r == S_IDLE) && fValid && chanHit && act && !full;
	wire        swap    = (state_r == S_IDLE) && fValid && !chanHit;
	wire [15:0] wordPos = used - 16'h1;
	wire [31:0] descA   = rxd_pkg::rxdDescAddr(descTableBase, cx_r.curRef);
	wire [1:0][15:0] freeNext;
	wire [1:0]  freeEmpty;
	for (genvar q = 0; q < 2; q++) begin : gFree
		assign freeNext[q]  = rxd_pkg::rxdNextIdx(freeRd_r[q], qStart[q], qEnd[q]);
		assign freeEmpty[q] = freeNext[q] == freeWrIdx[q];
	end
	wire        want    = act ? 1'(rxd_pkg::Q_LARGE) : 1'(rxd_pkg::Q_SMALL);
	wire        pick    = freeEmpty[want] ? !want : want;
	wire        noRef   = &freeEmpty;
	wire        rdyFull = readyRdIdx == readyWr_r;
	wire        busSt   = !(state_r inside {S_IDLE, S_GETREF}) && !(state_r == S_RDYQ && rdyFull);
	wire        isWr    = !(state_r inside {S_QRD, S_RDA, S_RDS});
	wire        step    = reqWrite_r ? (go_r && bus.reqReady) : (rdWait_r && bus.rspValid);
	wire [15:0] lastCnt = cx_r.cnt - {13'h0, trim_r};
	wire [9:0]  chCode  = {2'h0, cxChan_r};

	assign fReady        = take;
	assign bus.reqValid  = go_r && !rdWait_r;
	assign bus.reqWrite  = reqWrite_r;
	assign bus.reqAddr   = reqAddr_r;
	assign bus.reqData   = reqData_r;
	assign freeRdIdx     = freeRd_r;
	assign readyWrIdx    = readyWr_r;
	assign queueErrorIrq = (state_r == S_GETREF) && noRef && errArm_r;

	// request address and data for the current bus step
	always_comb
	begin
		addrC = descA + {28'h0, rxd_pkg::W_INFO};
		dataC = '0;
		unique case (state_r)
			S_WORD:
			begin
				addrC = cx_r.bufAddr + {16'h0, wordPos[15:2], 2'h0};
				dataC = cx_r.acc;
			end
			S_QRD: addrC = rxd_pkg::rxdQueueAddr(queueBase, freeNext[qSel_r]);
			S_LINK2:
			begin
				dataC[rxd_pkg::INFO_CNT +: 16] = cx_r.cnt;
				dataC[rxd_pkg::INFO_OFF +: 2]  = cx_r.off;
				dataC[rxd_pkg::INFO_CE]        = 1'b0;
			end
			S_CLOSE2:
			begin
				dataC[rxd_pkg::INFO_CNT +: 16] = lastCnt;
				dataC[rxd_pkg::INFO_STAT +: 6] = {1'b0, stat_r};
				dataC[rxd_pkg::INFO_OFF +: 2]  = cx_r.off;
				dataC[rxd_pkg::INFO_CE]        = 1'b1;
			end
			S_LINK3, S_CLOSE3:
			begin
				addrC = descA + {28'h0, rxd_pkg::W_LINK};
				dataC[rxd_pkg::LINK_CHAN +: 10] = chCode;
				if (state_r == S_LINK3)
					dataC[rxd_pkg::LINK_NEXT +: 15] = newRef_r;
			end
			S_RDA: addrC = descA + {28'h0, rxd_pkg::W_ADDR};
			S_RDS: addrC = descA + {28'h0, rxd_pkg::W_SIZE};
			S_RDYQ:
			begin
				addrC = rxd_pkg::rxdQueueAddr(queueBase, readyWr_r);
				dataC[rxd_pkg::RDY_CODE +: 2] = code_r;
				dataC[14:0] = cx_r.firstRef;
			end
			default: ;
		endcase
	end

	// channel table write-back
	always_ff @(posedge clk)
	begin
		if (swap)
			tbl[cxChan_r] <= cx_r;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn) begin
			state_r    <= S_IDLE;
			cx_r       <= '0;
			cxChan_r   <= 8'h00;
			act_r      <= '0;
			go_r       <= 1'b0;
			rdWait_r   <= 1'b0;
			qSel_r     <= 1'b0;
			newRef_r   <= 15'h0000;
			stat_r     <= 5'h00;
			trim_r     <= 3'h0;
			code_r     <= 2'h0;
			last_r     <= 1'b0;
			errArm_r   <= 1'b1;
			freeRd_r   <= '0;
			readyWr_r  <= 16'h0000;
			reqAddr_r  <= 32'h0000_0000;
			reqData_r  <= 32'h0000_0000;
			reqWrite_r <= 1'b0;
		end else begin
			if (qInit) begin
				freeRd_r[0] <= qEnd[rxd_pkg::Q_SMALL] - 16'h1;
				freeRd_r[1] <= qEnd[rxd_pkg::Q_LARGE] - 16'h1;
				readyWr_r   <= qStart[rxd_pkg::Q_READY];
			end
			// load request on the first cycle of a bus step
			if (busSt && !go_r && !rdWait_r) begin
				go_r       <= 1'b1;
				reqAddr_r  <= addrC;
				reqData_r  <= dataC;
				reqWrite_r <= isWr;
			end
			if (go_r && bus.reqReady) begin
				go_r     <= 1'b0;
				rdWait_r <= !reqWrite_r;
			end
			if (rdWait_r && bus.rspValid)
				rdWait_r <= 1'b0;
			unique case (state_r)
				S_IDLE:
				if (swap) begin
					cx_r     <= tbl[fChan];
					cxChan_r <= fChan;
				end else if (fValid && chanHit && (!act || full)) begin
					state_r <= S_GETREF;
				end else if (take) begin
					cx_r.acc[{cx_r.lane, 3'h0} +: 8] <= fByte;
					cx_r.lane <= cx_r.lane + 2'h1;
					cx_r.cnt  <= cx_r.cnt + 16'h1;
					last_r    <= fLast;
					stat_r    <= fStat;
					trim_r    <= fTrim;
					code_r    <= fUnprov ? rxd_pkg::RXD_UNPROV : fRawMax ? rxd_pkg::RXD_RAW_MAX_LIMIT :
						(fStat != 5'h00) ? rxd_pkg::RXD_FAIL : rxd_pkg::RXD_OK;
					if (cx_r.lane == 2'h3 || fLast)
						state_r <= S_WORD;
				end
				S_WORD:
				if (step)
					state_r <= last_r ? S_CLOSE2 : S_IDLE;
				S_GETREF:
				if (noRef) begin
					errArm_r <= 1'b0;
				end else begin
					qSel_r   <= pick;
					errArm_r <= 1'b1;
					state_r  <= S_QRD;
				end
				S_QRD:
				if (step) begin
					newRef_r         <= bus.rspData[14:0];
					freeRd_r[qSel_r] <= freeNext[qSel_r];
					if (act) begin
						state_r <= S_LINK2;
					end else begin
						cx_r.firstRef <= bus.rspData[14:0];
						cx_r.curRef   <= bus.rspData[14:0];
						cx_r.cnt      <= 16'h0000;
						cx_r.off      <= rxOffset;
						cx_r.lane     <= rxOffset;
						act_r[cxChan_r] <= 1'b1;
						state_r       <= S_RDA;
					end
				end
				S_LINK2:
				if (step)
					state_r <= S_LINK3;
				S_LINK3:
				if (step) begin
					cx_r.curRef <= newRef_r;
					cx_r.cnt    <= 16'h0000;
					cx_r.off    <= 2'h0;
					cx_r.lane   <= 2'h0;
					state_r     <= S_RDA;
				end
				S_RDA:
				if (step) begin
					cx_r.bufAddr <= bus.rspData;
					state_r      <= S_RDS;
				end
				S_RDS:
				if (step) begin
					cx_r.bufSize <= bus.rspData[15:0];
					state_r      <= S_IDLE;
				end
				S_CLOSE2:
				if (step)
					state_r <= S_CLOSE3;
				S_CLOSE3:
				if (step)
					state_r <= S_RDYQ;
				S_RDYQ:
				if (step) begin
					readyWr_r <= rxd_pkg::rxdNextIdx(readyWr_r, qStart[rxd_pkg::Q_READY],
						qEnd[rxd_pkg::Q_READY]);
					act_r[cxChan_r] <= 1'b0;
					state_r   <= S_IDLE;
				end
			endcase
		end
	end
endmodule : rxd_dma

// [core/rxd_pkg.sv]
package rxd_pkg;
	// channel table
	localparam int CHANNELS = 256;
	localparam int CH_W     = 8;
	localparam int CODE_W   = 10;
	// descriptor layout, byte offsets within a 16-byte descriptor
	localparam logic [3:0] W_ADDR = 4'h0;
	localparam logic [3:0] W_SIZE = 4'h4;
	localparam logic [3:0] W_INFO = 4'h8;
	localparam logic [3:0] W_LINK = 4'hC;
	localparam int INFO_CNT  = 0;
	localparam int INFO_STAT = 16;
	localparam int INFO_OFF  = 22;
	localparam int INFO_CE   = 24;
	localparam int LINK_NEXT = 0;
	localparam int LINK_CHAN = 16;
	localparam int STAT_OVR  = 0;
	localparam int STAT_ABT  = 4;
	localparam int RDY_CODE  = 15;
	localparam int REF_W     = 15;
	localparam int TABLE_W   = 19;
	localparam logic [15:0] BUF_MAX  = 16'h7FF0;
	localparam logic [15:0] CNT_MAX  = 16'h7FFF;
	// queue numbers
	localparam int Q_SMALL = 0;
	localparam int Q_LARGE = 1;
	localparam int Q_READY = 2;
	// ready element outcome
	typedef enum logic [1:0] {
		RXD_OK     = 2'h0,
		RXD_FAIL   = 2'h1,
		RXD_UNPROV = 2'h2,
		RXD_RAW_MAX_LIMIT = 2'h3
	} rxd_code_t;
	// per-channel dma context
	typedef struct packed {
		logic [14:0] firstRef;
		logic [14:0] curRef;
		logic [31:0] bufAddr;
		logic [15:0] bufSize;
		logic [15:0] cnt;
		logic [1:0]  off;
		logic [31:0] acc;
		logic [1:0]  lane;
	} rxd_ctx_t;

	// next queue index with wrap from end to start
	function automatic logic [15:0] rxdNextIdx(input logic [15:0] idx, input logic [15:0] st,
		input logic [15:0] en);
		logic [15:0] n;
		n = idx + 16'h1;
		return (n == en) ? st : n;
	endfunction : rxdNextIdx

	// descriptor address from table base and reference
	function automatic logic [31:0] rxdDescAddr(input logic [27:0] base, input logic [14:0] ref_);
		return {base, 4'h0} + {13'h0, ref_, 4'h0};
	endfunction : rxdDescAddr

	// queue element address
	function automatic logic [31:0] rxdQueueAddr(input logic [29:0] base, input logic [15:0] idx);
		return {base, 2'h0} + {14'h0, idx, 2'h0};
	endfunction : rxdQueueAddr
endpackage : rxd_pkg

// [core/rxd_if.sv]
`timescale 1ns/100ps
interface rxd_if;
	logic        reqValid;
	logic        reqReady;
	logic        reqWrite;
	logic [31:0] reqAddr;
	logic [31:0] reqData;
	logic        rspValid;
	logic [31:0] rspData;

	modport dev (output reqValid, input reqReady, output reqWrite, output reqAddr, output reqData,
		input rspValid, input rspData);
	modport ctl (input reqValid, output reqReady, input reqWrite, input reqAddr, input reqData,
		output rspValid, output rspData);
endinterface : rxd_if

// [core/rxd_host_ctl.sv]
`timescale 1ns/100ps
module rxd_host_ctl #(
	parameter int MEM_AW = 12
) (
	// engine side
	rxd_if.ctl                  bus,
	// clock and reset
	input  wire logic           clk,
	input  wire logic           rstn,
	// software port
	input  wire logic           swValid,
	input  wire logic           swWrite,
	input  wire logic [31:0]    swAddr,
	input  wire logic [31:0]    swWdata,
	output logic                swRvalid,
	output logic [31:0]         swRdata,
	// descriptor checks
	input  wire logic [27:0]    descTableBase,
	output logic                sizeErr,
	output logic                guardHit,
	output logic                rdStatusValid,
	output logic                rdBytesValid
);
	if (MEM_AW < 4 || MEM_AW > 30) begin : gBadAw
		$error("memory address width out of range");
	end
	logic [31:0] mem [2**MEM_AW];
	logic        rspValid_r;
	logic [31:0] rspData_r;

	// location of an address inside the descriptor table
	function automatic logic [3:0] descWord(input logic [31:0] a, input logic [27:0] base, output logic hit);
		logic [31:0] d;
		d   = a - {base, 4'h0};
		hit = d[31:rxd_pkg::TABLE_W] == '0;
		return d[3:0];
	endfunction : descWord

	logic       devHit;
	logic       swHit;
	logic [3:0] devW;
	logic [3:0] swW;
	always_comb
	begin
		devW = descWord(bus.reqAddr, descTableBase, devHit);
		swW  = descWord(swAddr, descTableBase, swHit);
	end
	wire         devTake  = bus.reqValid && bus.reqReady;
	wire         hostOwns = devHit && (devW == rxd_pkg::W_ADDR || devW == rxd_pkg::W_SIZE);
	wire         devWr    = devTake && bus.reqWrite && !hostOwns;
	wire         swWr     = swValid && swWrite;
	wire [15:0]  sz       = swWdata[15:0];
	wire         sizeOk   = sz != 16'h0000 && sz[3:0] == 4'h0 && sz <= rxd_pkg::BUF_MAX;
	wire [31:0]  swWord   = mem[swAddr[MEM_AW+1:2]];

	assign bus.reqReady = !swValid;
	assign bus.rspValid = rspValid_r;
	assign bus.rspData  = rspData_r;

	always_ff @(posedge clk)
	begin
		if (swWr)
			mem[swAddr[MEM_AW+1:2]] <= swWdata;
		else if (devWr)
			mem[bus.reqAddr[MEM_AW+1:2]] <= bus.reqData;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn) begin
			rspValid_r    <= 1'b0;
			rspData_r     <= 32'h0000_0000;
			swRvalid      <= 1'b0;
			swRdata       <= 32'h0000_0000;
			sizeErr       <= 1'b0;
			guardHit      <= 1'b0;
			rdStatusValid <= 1'b0;
			rdBytesValid  <= 1'b0;
		end else begin
			rspValid_r <= devTake && !bus.reqWrite;
			if (devTake && !bus.reqWrite)
				rspData_r <= mem[bus.reqAddr[MEM_AW+1:2]];
			swRvalid <= swValid && !swWrite;
			if (swValid && !swWrite)
				swRdata <= swWord;
			sizeErr  <= swWr && swHit && swW == rxd_pkg::W_SIZE && !sizeOk;
			guardHit <= devTake && bus.reqWrite && hostOwns;
			if (swValid && !swWrite && swHit && swW == rxd_pkg::W_INFO) begin
				rdStatusValid <= swWord[rxd_pkg::INFO_CE];
				rdBytesValid  <= !(swWord[rxd_pkg::INFO_STAT + rxd_pkg::STAT_OVR] ||
					swWord[rxd_pkg::INFO_STAT + rxd_pkg::STAT_ABT]);
			end
		end
	end
endmodule : rxd_host_ctl

// [testbench/rxd_bus_asserts.sv]
`timescale 1ns/100ps
module rxd_bus_asserts (
	// clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// request side
	input wire logic        reqValid,
	input wire logic        reqReady,
	input wire logic        reqWrite,
	input wire logic [31:0] reqAddr,
	input wire logic [31:0] reqData,
	// answer side
	input wire logic        rspValid,
	input wire logic [31:0] rspData
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic take;
	logic rdTake;
	assign take = reqValid && reqReady;
	assign rdTake = take && !reqWrite;
	AST_REQ_HOLD: assert property (reqValid && !reqReady |=> reqValid && $stable({reqWrite, reqAddr, reqData}))
		else $error("request changed before it was taken");
	AST_READ_ANSWER: assert property (rdTake |=> rspValid)
		else $error("read not answered one cycle after take");
	AST_NO_SPURIOUS_RSP: assert property (rspValid |-> $past(rdTake))
		else $error("answer without a read");
	AST_RSP_PULSE: assert property (rspValid |=> !rspValid)
		else $error("answer longer than one cycle");
	AST_ONE_OUTSTANDING: assert property (take |=> !take)
		else $error("requests taken back to back");
	AST_READ_SPACING: assert property (rdTake |=> !take [*2])
		else $error("request too soon after a read");
	AST_RSP_DATA_STANDS: assert property ($changed(rspData) |-> rspValid)
		else $error("read data changed without an answer");
	AST_WORD_ALIGNED: assert property (reqValid |-> reqAddr[1:0] == 2'h0)
		else $error("unaligned request address");
endmodule : rxd_bus_asserts

// [testbench/testbench.sv]
`timescale 1ns/100ps
module testbench;
	logic             clk = 1'b0;
	logic             rstn = 1'b0;
	logic             inValid = 1'b0, inLast = 1'b0, inUnprov = 1'b0, inRawMax = 1'b0, qInit = 1'b0;
	logic             inReady, queueErrorIrq, swRvalid, sizeErr, guardHit, rdStatusValid, rdBytesValid;
	logic             swValid = 1'b0, swWrite = 1'b0, se = 1'b0, gh = 1'b0, qe = 1'b0;
	logic [7:0]       inData = 8'h00, inChan = 8'h00;
	logic [4:0]       inStatus = 5'h00;
	logic [2:0]       inTrim = 3'h0;
	logic [1:0]       rxOffset = 2'h0;
	logic [27:0]      descTableBase = 28'h0000300;
	logic [29:0]      queueBase = 30'h0;
	logic [31:0]      swAddr = 32'h0, swWdata = 32'h0, swRdata, q;
	logic [15:0]      readyWrIdx, readyRdIdx = 16'h001F;
	logic [1:0][15:0] freeRdIdx, freeWrIdx = 32'h000A0002;
	logic [2:0][15:0] qStart = 48'h001000080000, qEnd = 48'h002000100008;
	logic [7:0]       bq[$];
	int               nMismatch = 0, nCompared = 0;

	always #12.5 clk = ~clk;
	// sticky capture of one-cycle flags
	always @(posedge clk)
	begin
		se <= se | (sizeErr === 1'b1);
		gh <= gh | (guardHit === 1'b1);
		qe <= qe | (queueErrorIrq === 1'b1);
	end

	rxd_if busIf ();
	rxd_dma #(.FIFO_DEPTH(16)) rxd_dma_i (.bus(busIf), .clk(clk), .rstn(rstn), .inValid(inValid),
		.inReady(inReady), .inData(inData), .inChan(inChan), .inLast(inLast), .inStatus(inStatus),
		.inTrim(inTrim), .inUnprov(inUnprov), .inRawMax(inRawMax), .descTableBase(descTableBase),
		.queueBase(queueBase), .rxOffset(rxOffset), .qInit(qInit), .qStart(qStart), .qEnd(qEnd),
		.freeWrIdx(freeWrIdx), .readyRdIdx(readyRdIdx), .freeRdIdx(freeRdIdx), .readyWrIdx(readyWrIdx),
		.queueErrorIrq(queueErrorIrq));
	rxd_host_ctl #(.MEM_AW(12)) rxd_host_ctl_i (.bus(busIf), .clk(clk), .rstn(rstn), .swValid(swValid),
		.swWrite(swWrite), .swAddr(swAddr), .swWdata(swWdata), .swRvalid(swRvalid), .swRdata(swRdata),
		.descTableBase(descTableBase), .sizeErr(sizeErr), .guardHit(guardHit),
		.rdStatusValid(rdStatusValid), .rdBytesValid(rdBytesValid));
	rxd_bus_asserts rxd_bus_asserts_i (.clk(clk), .rstn(rstn), .reqValid(busIf.reqValid),
		.reqReady(busIf.reqReady), .reqWrite(busIf.reqWrite), .reqAddr(busIf.reqAddr),
		.reqData(busIf.reqData), .rspValid(busIf.rspValid), .rspData(busIf.rspData));

	task automatic giveVerdict();
		if (nMismatch == 0 && nCompared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : giveVerdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			nMismatch++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [31:0] dAddr(input logic [14:0] r);
		return 32'h00003000 + {13'h0, r, 4'h0};
	endfunction : dAddr

	function automatic logic [31:0] bAddr(input logic [14:0] r);
		return 32'h00002000 + {9'h0, r, 8'h0};
	endfunction : bAddr

	function automatic logic [1:0] expCode(input logic [4:0] st, input logic un, input logic rw);
		return un ? rxd_pkg::RXD_UNPROV : rw ? rxd_pkg::RXD_RAW_MAX_LIMIT :
			(st != 5'h0) ? rxd_pkg::RXD_FAIL : rxd_pkg::RXD_OK;
	endfunction : expCode

	// software access, holds off the engine for its cycle
	task automatic swAcc(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		@(negedge clk);
		swValid = 1'b1;
		swWrite = wr;
		swAddr = a;
		swWdata = d;
		@(negedge clk);
		swValid = 1'b0;
		r = 32'h0;
		for (int i = 0; i < 4 && !wr; i++)
		begin
			if (swRvalid === 1'b1)
			begin
				r = swRdata;
				break;
			end
			@(negedge clk);
		end
	endtask : swAcc

	task automatic sendPkt(input logic [7:0] ch, input int n, input logic [4:0] st, input logic [2:0] tr,
		input logic un, input logic rw);
		for (int k = 0; k < n; k++)
		begin
			@(negedge clk);
			for (int w = 0; w < 100 && inReady !== 1'b1; w++)
			begin
				inValid = 1'b0;
				@(negedge clk);
			end
			inValid = 1'b1;
			inChan = ch;
			inData = 8'($urandom);
			bq.push_back(inData);
			inLast = (k == n - 1);
			inStatus = st;
			inTrim = tr;
			inUnprov = un;
			inRawMax = rw;
		end
		@(negedge clk);
		inValid = 1'b0;
	endtask : sendPkt

	task automatic descCheck(input logic [14:0] r, input logic [15:0] c, input logic [4:0] st, input logic [1:0] o,
		input logic ce, input logic [14:0] nx, input logic [7:0] ch);
		logic [31:0] v;
		logic [31:0] m;
		swAcc(1'b0, dAddr(r), 32'h0, v);
		check(v, bAddr(r));
		swAcc(1'b0, dAddr(r) + 32'h8, 32'h0, v);
		check(v, {7'h0, ce, o, 1'b0, st, c});
		check({31'h0, rdStatusValid}, {31'h0, ce});
		check({31'h0, rdBytesValid}, {31'h0, !(st[0] | st[4])});
		swAcc(1'b0, dAddr(r) + 32'hC, 32'h0, v);
		m = ce ? 32'hFFFF8000 : 32'hFFFFFFFF;
		check(v & m, {8'h0, ch, 1'b0, nx} & m);
	endtask : descCheck

	task automatic dataChk(input logic [14:0] r, input int o, input int k0, input int c);
		logic [31:0] v;
		logic [31:0] a;
		for (int j = 0; j < c; j++)
		begin
			a = bAddr(r) + 32'(o + j);
			swAcc(1'b0, {a[31:2], 2'h0}, 32'h0, v);
			check({24'h0, v[8 * a[1:0] +: 8]}, {24'h0, bq[k0 + j]});
		end
	endtask : dataChk

	task automatic runPkt(input int k, input logic [14:0] r, input logic [14:0] nx, input int n,
		input logic [4:0] st, input logic [2:0] tr, input logic un, input logic rw, input logic starve);
		logic [31:0] v;
		logic [7:0]  ch;
		int          k0;
		int          c1;
		ch = 8'($urandom);
		k0 = bq.size();
		sendPkt(ch, n, st, tr, un, rw);
		if (starve)
		begin
			for (int w = 0; w < 100 && qe !== 1'b1; w++)
				@(negedge clk);
			check({31'h0, qe}, 32'h1);
			// fill the byte fifo behind the starved engine
			inLast = 1'b0;
			c1 = 0;
			for (int i = 0; i < 20 && inReady === 1'b1; i++)
			begin
				inValid = 1'b1;
				c1++;
				@(negedge clk);
			end
			inValid = 1'b0;
			check(32'(c1), 32'h0000000F);
			swAcc(1'b1, 32'h28, 32'h5, v);
			freeWrIdx[1] = 16'h000B;
		end
		for (int w = 0; w < 300 && readyWrIdx !== 16'(17 + k); w++)
			swAcc(1'b0, 32'h0, 32'h0, v);
		if (starve)
			check({31'h0, inReady}, 32'h1);
		swAcc(1'b0, 32'(64 + 4 * k), 32'h0, v);
		check(v, {15'h0, expCode(st, un, rw), r});
		c1 = (nx != 0) ? 16 - rxOffset : n - tr;
		descCheck(r, 16'(c1), (nx != 0) ? 5'h0 : st, rxOffset, nx == 0, nx, ch);
		dataChk(r, rxOffset, k0, (c1 < 0) ? 0 : c1);
		if (nx != 0)
		begin
			descCheck(nx, 16'(n - c1 - tr), st, 2'h0, 1'b1, 15'h0, ch);
			dataChk(nx, 0, k0 + c1, n - c1 - tr);
		end
	endtask : runPkt

	initial
	begin
		void'($urandom(26543));
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		check({31'h0, inReady}, 32'h1);
		rxOffset = 2'($urandom);
		for (int r = 1; r < 6; r++)
		begin
			swAcc(1'b1, dAddr(15'(r)), bAddr(15'(r)), q);
			swAcc(1'b1, dAddr(15'(r)) + 32'h4, (r < 3) ? 32'h10 : 32'h40, q);
		end
		for (int i = 0; i < 4; i++)
			swAcc(1'b1, (i < 2) ? 32'(4 * i) : 32'(24 + 4 * i), 32'(i + 1), q);
		check({31'h0, se}, 32'h0);
		@(negedge clk);
		qInit = 1'b1;
		@(negedge clk);
		qInit = 1'b0;
		runPkt(0, 15'h1, 15'h0, 1 + $urandom % (16 - rxOffset), 5'h0, 3'h0, 1'b0, 1'b0, 1'b0);
		runPkt(1, 15'h2, 15'h3, 21 - rxOffset, 5'($urandom) | 5'h1, 3'h0, 1'b0, 1'b0, 1'b0);
		runPkt(2, 15'h4, 15'h0, 8, 5'($urandom), 3'h2, 1'b1, 1'b0, 1'b0);
		check(freeRdIdx, 32'h00090001);
		check({31'h0, qe}, 32'h0);
		runPkt(3, 15'h5, 15'h0, 1, 5'h0, 3'h2, 1'b0, 1'b1, 1'b1);
		swAcc(1'b1, dAddr(15'h6) + 32'h4, 32'h18, q);
		repeat (3) @(negedge clk);
		check({31'h0, se}, 32'h1);
		check({31'h0, gh}, 32'h0);
		giveVerdict();
	end

	// watchdog
	initial
	begin
		#1000000;
		nMismatch++;
		giveVerdict();
	end
endmodule : testbench
